// *** design/smr_pkg.sv ***
// Constants and types shared by the serial memory read controller
package smr_pkg;
    localparam int ADDR_W = 13;
    localparam int DEPTH = 8192;
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [12:0] ADDR_RST = 13'h0000;
    localparam logic [12:0] ADDR_LAST = 13'h1fff;
    localparam logic [12:0] ADDR_FIRST = 13'h0000;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam int DEV_TYPE_MSB = 7;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_SEL_MSB = 3;
    localparam int DEV_SEL_LSB = 1;
    localparam int RW_POS = 0;
    localparam int ADDR_HI_W = 5;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RX,
        S_ACK,
        S_TX,
        S_MACK
    } smr_state_type;

    typedef enum logic [1:0] {
        K_DEV,
        K_AHI,
        K_ALO,
        K_DATA
    } smr_kind_type;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } smr_mem_req_type;
endpackage

// *** design/smr_mem.sv ***
// Byte array of the serial memory with registered read data
module smr_mem (
    input wire logic clk_i,
    input wire smr_pkg::smr_mem_req_type req_i,
    output logic [7:0] rd_data_o
);
    import smr_pkg::*;

    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (req_i.we) begin
            mem_q[req_i.addr] <= req_i.data;
        end
    end

    // Read always follows the address, so data is ready long before a bus bit
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_q[req_i.addr];
    end
endmodule // smr_mem

// *** design/smr_read_ctrl.sv ***
// Two-wire serial memory target: addressing, selective and sequential reads
module smr_read_ctrl (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic [2:0] DEVICE_SELECT_PINS_I,
    output logic SDA_O,
    output logic SDA_OE_O
);
    import smr_pkg::*;

    // Link domain: capture data bit and flag each rising clock edge
    logic lrst_s1_q, lrst_s2_q;
    logic link_tgl_q, link_bit_q;

    always_ff @(posedge SCL_I) begin
        lrst_s1_q <= RESET_I;
        lrst_s2_q <= lrst_s1_q;
    end

    always_ff @(posedge SCL_I) begin
        if (lrst_s2_q) begin
            link_tgl_q <= 1'b0;
            link_bit_q <= 1'b1;
        end else begin
            link_bit_q <= SDA_I;
            link_tgl_q <= ~link_tgl_q;
        end
    end

    // System domain synchronisers
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic tgl_s1_q, tgl_s2_q, tgl_s3_q, tgl_s4_q;
    logic bit_s1_q, bit_s2_q;
    logic [2:0] sel_s1_q, sel_s2_q;

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
            tgl_s1_q <= 1'b0;
            tgl_s2_q <= 1'b0;
            tgl_s3_q <= 1'b0;
            tgl_s4_q <= 1'b0;
            bit_s1_q <= 1'b1;
            bit_s2_q <= 1'b1;
            sel_s1_q <= 3'h0;
            sel_s2_q <= 3'h0;
        end else begin
            scl_s1_q <= SCL_I;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= SDA_I;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
            tgl_s1_q <= link_tgl_q;
            tgl_s2_q <= tgl_s1_q;
            tgl_s3_q <= tgl_s2_q;
            tgl_s4_q <= tgl_s3_q;
            bit_s1_q <= link_bit_q;
            bit_s2_q <= bit_s1_q;
            sel_s1_q <= DEVICE_SELECT_PINS_I;
            sel_s2_q <= sel_s1_q;
        end
    end

    // Event taken one stage late so the captured bit has settled
    logic rise_ev, fall_ev, start_ev, stop_ev, rx_bit;
    assign rise_ev = tgl_s3_q ^ tgl_s4_q;
    assign rx_bit = bit_s2_q;
    assign fall_ev = scl_s3_q & ~scl_s2_q;
    assign start_ev = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_ev = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

    function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
        dev_match = (b[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE) && (b[DEV_SEL_MSB:DEV_SEL_LSB] == sel);
    endfunction
    smr_state_type state_q;
    smr_kind_type kind_q;
    logic [2:0] bitcnt_q;
    logic [7:0] rx_q, tx_q;
    logic read_q, ack_seen_q, out_low_q, last_q;
    logic [ADDR_HI_W-1:0] addr_hi_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] rd_data;
    logic [7:0] rx_full;
    logic byte_done, addr_inc, addr_load;
    smr_mem_req_type mem_req;

    assign rx_full = {rx_q[6:0], rx_bit};
    assign byte_done = (state_q == S_RX) && rise_ev && (bitcnt_q == BIT_LAST) && !start_ev && !stop_ev;
    assign addr_load = byte_done && (kind_q == K_ALO);
    // Data byte stored only once all eight bits arrived; an earlier start leaves memory alone
    assign mem_req.we = byte_done && (kind_q == K_DATA);
    assign mem_req.addr = addr_q;
    assign mem_req.data = rx_full;
    // Advance after each data byte written or read, just before its acknowledge slot
    assign addr_inc = mem_req.we || ((state_q == S_TX) && rise_ev && (bitcnt_q == BIT_LAST));

    smr_mem u_mem (
        .clk_i(CLK_I),
        .req_i(mem_req),
        .rd_data_o(rd_data)
    );

    // Address latch survives every abort; only a power-up reset clears it
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            addr_q <= ADDR_RST;
        end else if (addr_load) begin
            addr_q <= {addr_hi_q, rx_full};
        end else if (addr_inc) begin
            addr_q <= (addr_q == ADDR_LAST) ? ADDR_FIRST : addr_q + 13'h0001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            state_q <= S_IDLE;
            kind_q <= K_DEV;
            bitcnt_q <= BIT_FIRST;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
            read_q <= 1'b0;
            ack_seen_q <= 1'b0;
            out_low_q <= 1'b0;
            last_q <= 1'b0;
            addr_hi_q <= 5'h00;
        end else if (start_ev) begin
            state_q <= S_RX;
            kind_q <= K_DEV;
            bitcnt_q <= BIT_FIRST;
            out_low_q <= 1'b0;
            read_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= S_IDLE;
            out_low_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    out_low_q <= 1'b0;
                end
                S_RX: begin
                    if (rise_ev) begin
                        rx_q <= rx_full;
                        bitcnt_q <= bitcnt_q + 3'h1;
                        if (bitcnt_q == BIT_LAST) begin
                            ack_seen_q <= 1'b0;
                            state_q <= S_ACK;
                            case (kind_q)
                                K_DEV: begin
                                    if (!dev_match(rx_full, sel_s2_q)) begin
                                        state_q <= S_IDLE;
                                    end
                                    read_q <= rx_full[RW_POS];
                                    kind_q <= K_AHI;
                                end
                                K_AHI: begin
                                    addr_hi_q <= rx_full[ADDR_HI_W-1:0];
                                    kind_q <= K_ALO;
                                end
                                default: begin
                                    kind_q <= K_DATA;
                                end
                            endcase
                        end
                    end
                end
                S_ACK: begin
                    if (rise_ev) begin
                        ack_seen_q <= 1'b1;
                    end
                    if (fall_ev) begin
                        if (!ack_seen_q) begin
                            out_low_q <= 1'b1;
                        end else if (read_q) begin
                            // Read data from the latch location, no address bytes taken
                            state_q <= S_TX;
                            bitcnt_q <= BIT_FIRST;
                            last_q <= 1'b0;
                            out_low_q <= ~rd_data[7];
                            tx_q <= {rd_data[6:0], 1'b0};
                        end else begin
                            state_q <= S_RX;
                            bitcnt_q <= BIT_FIRST;
                            out_low_q <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (rise_ev) begin
                        bitcnt_q <= bitcnt_q + 3'h1;
                        if (bitcnt_q == BIT_LAST) begin
                            last_q <= 1'b1;
                        end
                    end
                    if (fall_ev) begin
                        if (last_q) begin
                            out_low_q <= 1'b0;
                            ack_seen_q <= 1'b0;
                            state_q <= S_MACK;
                        end else begin
                            out_low_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                S_MACK: begin
                    if (rise_ev) begin
                        if (rx_bit) begin
                            state_q <= S_IDLE;
                        end else begin
                            ack_seen_q <= 1'b1;
                        end
                    end else if (fall_ev && ack_seen_q) begin
                        // Keeps going while acknowledged; a no-acknowledge or a stop returns it to idle with the line released
                        state_q <= S_TX;
                        bitcnt_q <= BIT_FIRST;
                        last_q <= 1'b0;
                        out_low_q <= ~rd_data[7];
                        tx_q <= {rd_data[6:0], 1'b0};
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            SDA_O <= 1'b0;
            SDA_OE_O <= 1'b0;
        end else begin
            SDA_O <= 1'b0;
            SDA_OE_O <= out_low_q;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);

    dev_reject_a: assert property (byte_done && kind_q == K_DEV && !dev_match(rx_full, sel_s2_q)
        |=> state_q == S_IDLE)
        else $error("foreign address byte was accepted");
    first_bit_a: assert property (state_q == S_ACK && fall_ev && ack_seen_q && read_q && !start_ev && !stop_ev
        |=> state_q == S_TX ##0 out_low_q == ~$past(rd_data[7]) ##2 SDA_OE_O == out_low_q)
        else $error("first read bit not from latch location");
    addr_step_a: assert property (state_q == S_TX && rise_ev && bitcnt_q == BIT_LAST && !start_ev && !stop_ev
        |=> addr_q == 13'($past(addr_q) + 13'h0001))
        else $error("address not advanced after read byte");
    addr_wrap_a: assert property (addr_inc && !addr_load && addr_q == ADDR_LAST |=> addr_q == ADDR_FIRST)
        else $error("address did not wrap to zero");
    addr_load_a: assert property (addr_load |=> addr_q == {$past(addr_hi_q), $past(rx_full)})
        else $error("address latch not loaded from address bytes");
    abort_stop_a: assert property (stop_ev |=> state_q == S_IDLE && !out_low_q ##2 !SDA_OE_O)
        else $error("stop did not abort operation");
    start_abort_a: assert property (start_ev |=> state_q == S_RX && kind_q == K_DEV && !out_low_q
        && !mem_req.we)
        else $error("start did not restart addressing");
    nack_end_a: assert property (state_q == S_MACK && rise_ev && rx_bit && !start_ev && !stop_ev
        |=> state_q == S_IDLE && !out_low_q)
        else $error("read continued after no-acknowledge");
    mack_free_a: assert property (state_q == S_MACK |-> !out_low_q)
        else $error("data line driven in master acknowledge slot");
    ack_next_a: assert property (state_q == S_MACK && fall_ev && ack_seen_q && !start_ev && !stop_ev
        |=> state_q == S_TX && bitcnt_q == BIT_FIRST)
        else $error("next byte not started after acknowledge");
    low_change_a: assert property ($rose(out_low_q) |-> $past(fall_ev))
        else $error("data driven low outside clock-low phase");
endmodule // smr_read_ctrl

// *** tb/smr_bus_master.sv ***
// Behavioural two-wire bus master driving the serial memory target
module smr_bus_master (
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quarter bit of 14 x 6 ns = 84 ns; over eight 10 ns clocks so the target's synchronisers keep up
    localparam int T = 14 * 6;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // Data moves only while the clock is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        #T sda_oe_o = ~b;
        #T scl_o = 1'b1;
        #T r = sda_i;
        #T scl_o = 1'b0;
    endtask

    // Also serves as a start in the 9th or 10th clock
    task automatic start_c();
        #T sda_oe_o = 1'b0;
        #T scl_o = 1'b1;
        #T sda_oe_o = 1'b1;
        #T scl_o = 1'b0;
    endtask

    // Also serves as a stop in the 9th or 10th clock
    task automatic stop_c();
        #T sda_oe_o = 1'b1;
        #T scl_o = 1'b1;
        #T sda_oe_o = 1'b0;
        #T;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Mode 0 acknowledges, 1 withholds it, 2 leaves the slot to the caller
    task automatic recv_byte(input logic [1:0] mode, output logic [7:0] d, output logic slot);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        slot = 1'b1;
        if (mode != 2'h2) bit_io(mode[0], slot);
    endtask
endmodule // smr_bus_master

// *** tb/serial_memory_read_control_test.sv ***
// Self-checking bench for the serial memory read controller
module serial_memory_read_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] pins = 3'h5;
    logic scl;
    logic m_oe;
    logic sda_oe;
    logic sda_o;
    // Open-drain line with pull-up
    wire logic sda = ~(m_oe | (sda_oe & ~sda_o));
    int n_errors = 0;
    int checks = 0;

    always #5 clk = ~clk;

    smr_read_ctrl uut (
        .CLK_I(clk),
        .RESET_I(rst),
        .SCL_I(scl),
        .SDA_I(sda),
        .DEVICE_SELECT_PINS_I(pins),
        .SDA_O(sda_o),
        .SDA_OE_O(sda_oe)
    );

    smr_bus_master m (
        .scl_o(scl),
        .sda_oe_o(m_oe),
        .sda_i(sda)
    );

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] dev(input logic [3:0] ty, input logic [2:0] s, input logic rw);
        return {ty, s, rw};
    endfunction

    task automatic tx(input logic [7:0] d, input logic exp_ack);
        logic ack;
        m.send_byte(d, ack);
        cmp8({7'h0, ack}, {7'h0, exp_ack});
    endtask

    task automatic rd(input logic [1:0] mode, input logic [7:0] exp);
        logic [7:0] d;
        logic slot;
        m.recv_byte(mode, d, slot);
        cmp8(d, exp);
        if (mode == 2'h1) cmp8({7'h0, slot}, 8'h01);
    endtask

    task automatic set_addr(input logic [2:0] s, input logic [12:0] a);
        m.start_c();
        tx(dev(smr_pkg::DEV_TYPE, s, 1'b0), 1'b1);
        tx({3'h0, a[12:8]}, 1'b1);
        tx(a[7:0], 1'b1);
    endtask

    task automatic read_cmd(input logic [2:0] s);
        tx(dev(smr_pkg::DEV_TYPE, s, 1'b1), 1'b1);
    endtask

    task automatic t_write();
        set_addr(3'h5, 13'h1ffe);
        tx(8'ha5, 1'b1);
        tx(8'h5a, 1'b1);
        tx(8'h3c, 1'b1);
        tx(8'hc3, 1'b1);
        m.stop_c();
        $display("test write fill done");
    endtask

    task automatic t_selective();
        set_addr(3'h5, 13'h1ffe);
        m.start_c();
        read_cmd(3'h5);
        rd(2'h0, 8'ha5);
        rd(2'h0, 8'h5a);
        rd(2'h1, 8'h3c);
        m.stop_c();
        cmp8({7'h0, sda_oe}, 8'h00);
        $display("test selective read done");
    endtask

    task automatic t_current();
        m.start_c();
        read_cmd(3'h5);
        rd(2'h1, 8'hc3);
        m.start_c();
        m.stop_c();
        cmp8({7'h0, sda_oe}, 8'h00);
        $display("test current read done");
    endtask

    task automatic t_endings();
        set_addr(3'h5, 13'h1fff);
        m.start_c();
        read_cmd(3'h5);
        rd(2'h2, 8'h5a);
        m.stop_c();
        cmp8({7'h0, sda}, 8'h01);
        m.start_c();
        read_cmd(3'h5);
        rd(2'h2, 8'h3c);
        m.start_c();
        read_cmd(3'h5);
        rd(2'h1, 8'hc3);
        m.stop_c();
        $display("test read endings done");
    endtask

    task automatic t_select();
        m.start_c();
        tx(dev(smr_pkg::DEV_TYPE, 3'h3, 1'b1), 1'b0);
        m.stop_c();
        m.start_c();
        tx(dev(4'hb, 3'h5, 1'b1), 1'b0);
        m.stop_c();
        @(posedge clk) pins <= 3'h3;
        repeat (8) @(posedge clk);
        set_addr(3'h3, 13'h1ffe);
        m.start_c();
        read_cmd(3'h3);
        rd(2'h1, 8'ha5);
        m.stop_c();
        $display("test device select done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        logic r;
        // Link-side capture flops need bus clock edges while in reset
        repeat (4) m.bit_io(1'b1, r);
        @(posedge clk) rst <= 1'b0;
        // Link-side reset lets go only after two more bus clocks
        repeat (2) m.bit_io(1'b1, r);
        repeat (10) @(posedge clk);
        t_write();
        t_selective();
        t_current();
        t_endings();
        t_select();
        complete_run();
    end

    // About 35 bytes of 3 us each; roughly three times that
    initial begin
        #300000;
        n_errors++;
        complete_run();
    end
endmodule // serial_memory_read_control_test
